// >>> dio_ecs_asserts.sv
// Concurrent checks on the pins and the status lamp of the digital I/O block.
// Assumes one clock, an active-high async reset and a short blink period.
`timescale 1ns/10ps
`include "dio_params.svh"

module dio_ecs_asserts #(
    parameter logic [`DIO_BLINK_W-1:0] BLINK_HALF_CYCLES = 24'h8
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  s_axi_bvalid,
    input  wire logic                  usb_link_up,
    input  wire logic                  usb_xfer_busy,
    input  wire logic [`DIO_LINES-1:0] dio_out,
    input  wire logic [`DIO_LINES-1:0] dio_oe_n,
    input  wire logic                  status_lamp
);
    localparam int GREET = 6 * BLINK_HALF_CYCLES + 4;
    localparam int BL    = 2 * BLINK_HALF_CYCLES + 2;
    logic [15:0] up_cnt;
    logic [2:0]  falls;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Saturating cycles since link-up, and lamp falls seen during the greeting.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_cnt <= 16'h0;
            falls  <= 3'h0;
        end else begin
            if (!usb_link_up) begin
                up_cnt <= 16'h0;
                falls  <= 3'h0;
            end else begin
                if (up_cnt != 16'hFFFF) up_cnt <= up_cnt + 16'h1;
                if ($fell(status_lamp) && up_cnt <= 16'(GREET)) falls <= falls + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The greeting starts on the edge after the link rises.
    sequence s_link_rise;
        $rose(usb_link_up);
    endsequence

    // Pin direction, output latches and lamp behaviour.
    a_reset_all_inputs: assert property ($past(sys_rst) |-> dio_oe_n == 24'hFFFFFF)
        else $error("Lines driven on the first edge after reset.");
    a_ports_whole: assert property (dio_oe_n[7:0] inside {8'h00, 8'hFF} && dio_oe_n[15:8] inside {8'h00, 8'hFF})
        else $error("A port has mixed directions.");
    a_third_halves: assert property (dio_oe_n[19:16] inside {4'h0, 4'hF} && dio_oe_n[23:20] inside {4'h0, 4'hF})
        else $error("A half of the third port has mixed directions.");
    a_out_on_write: assert property ($changed(dio_out) || $changed(dio_oe_n) |-> $rose(s_axi_bvalid))
        else $error("Line drive changed without a completed write.");
    a_greet_start: assert property (s_link_rise |=> status_lamp)
        else $error("Lamp not lit after the link came up.");
    a_greet_three: assert property (up_cnt == 16'(GREET) |-> falls == 3'h3)
        else $error("Greeting did not blink three times.");
    a_lamp_steady: assert property (up_cnt > 16'(GREET) && !usb_xfer_busy && !$past(usb_xfer_busy) |-> status_lamp)
        else $error("Lamp not steady while idle on the link.");
    a_busy_blinks: assert property (up_cnt > 16'(GREET) && usb_xfer_busy |->
        ##[1:BL] ($changed(status_lamp) || !usb_xfer_busy || !usb_link_up))
        else $error("Lamp not blinking during transfers.");
    a_lamp_off: assert property (!usb_link_up |=> !status_lamp)
        else $error("Lamp lit without a link.");
endmodule : dio_ecs_asserts

bind dio_event_counter_status dio_ecs_asserts #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid), .usb_link_up(usb_link_up),
    .usb_xfer_busy(usb_xfer_busy), .dio_out(dio_out), .dio_oe_n(dio_oe_n), .status_lamp(status_lamp));

// >>> dio_event_counter_status.sv
// Digital I/O block: three 8-bit ports, a 32-bit event counter and a status lamp.
// Assumes an AXI4-Lite master and a USB link engine, both on clk,
// and pad logic that resolves each line from its enable.
//
// Functional notes
// - There are twenty-four general digital lines in three eight-bit ports.
// - Software picks input or output per port and each port follows its own setting.
// - An input line reads 1 when driven high and 0 when grounded.
// - The lamp is lit steadily while attached and enumerated with no transfer running.
// - The lamp blinks continuously while transfers with the host are running.
// - When the link first comes up the lamp blinks three times and then stays lit.
// - When the link is lost the lamp goes off until the link is established again.
// - Nothing can disable the status lamp.
// - One thirty-two-bit event counter is fed from the event count input.
// - The counter adds one on each rising edge and ignores falling edges.
// - The counter catches every rising edge up to the maximum input rate.
// - After reset every port is an input.
// - Direction works as three eight-bit groups or two groups plus two halves of the third port.
`timescale 1ns/10ps
`include "dio_params.svh"

module dio_event_counter_status #(
    parameter logic [`DIO_BLINK_W-1:0] BLINK_HALF_CYCLES = `DIO_BLINK_W'(`DIO_BLINK_HALF_NS / `DIO_CLK_PERIOD_NS)
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // AXI4-Lite slave.
    input  wire logic [`DIO_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`DIO_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Link state from the USB engine, same clock.
    input  wire logic                    usb_link_up,
    input  wire logic                    usb_xfer_busy,
    // Digital lines: first port in bits 7:0, second 15:8, third 23:16.
    input  wire logic [`DIO_LINES-1:0]   dio_in,
    output logic [`DIO_LINES-1:0]        dio_out,
    output logic [`DIO_LINES-1:0]        dio_oe_n,
    // Event counter terminal and status lamp.
    input  wire logic                    event_count_input,
    output logic                         status_lamp
);

    dio_pkg::dio_core_s    core_reg;
    dio_pkg::dio_core_s    core_next;
    logic [31:0]           wr_word;
    logic [`DIO_COUNT_W-1:0] count_base;
    logic                  rise;
    logic                  lamp_q;
    logic [2:0]            link_bits;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // An address is mapped when word aligned and inside the register window.
    function automatic logic is_mapped(input logic [`DIO_ADDR_W-1:0] addr);
        is_mapped = (addr[1:0] == 2'h0) && (addr <= `DIO_OFS_LAST);
    endfunction : is_mapped

    // Strobed byte lanes take the new data, the others keep the old.
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
        end
    endfunction : merge

    // Per-line output mask; with the split bit clear the third port moves as one group.
    function automatic logic [`DIO_LINES-1:0] dir_mask(input logic [`DIO_CFG_W-1:0] cfg);
        logic chi;
        chi = cfg[`DIO_CFG_SPLIT_C] ? cfg[`DIO_CFG_DIR_CHI] : cfg[`DIO_CFG_DIR_CLO];
        dir_mask = {{4{chi}}, {4{cfg[`DIO_CFG_DIR_CLO]}},
                    {`DIO_PORT_W{cfg[`DIO_CFG_DIR_B]}},
                    {`DIO_PORT_W{cfg[`DIO_CFG_DIR_A]}}};
    endfunction : dir_mask

    // Register contents as seen by a read, also the base of a strobed write.
    function automatic logic [31:0] reg_word(input logic [`DIO_ADDR_W-1:0] addr,
                                             input dio_pkg::dio_core_s s,
                                             input logic [2:0] link);
        reg_word = 32'h0000_0000;
        case (addr)
            `DIO_OFS_CFG:    reg_word[`DIO_CFG_W-1:0] = s.cfg;
            `DIO_OFS_OUT_A:  reg_word[7:0] = s.out_lat[7:0];
            `DIO_OFS_OUT_B:  reg_word[7:0] = s.out_lat[15:8];
            `DIO_OFS_OUT_C:  reg_word[7:0] = s.out_lat[23:16];
            `DIO_OFS_PIN_IN: reg_word[`DIO_LINES-1:0] = s.pin_sync;
            `DIO_OFS_COUNT:  reg_word = s.count;
            `DIO_OFS_LINK:   reg_word[2:0] = link;
            default:         reg_word = 32'h0000_0000;
        endcase
    endfunction : reg_word

    ////////////////////////////////////////////////////////////////////////////////
    // Status lamp; it reads only the link state, so no setting turns it off.

    dio_status_lamp #(
        .BLINK_HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_lamp (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .link_up   (usb_link_up),
        .xfer_busy (usb_xfer_busy),
        .lamp_on   (lamp_q)
    );

    // Link status bits as software reads them.
    assign link_bits = {lamp_q, usb_xfer_busy, usb_link_up};

    ////////////////////////////////////////////////////////////////////////////////
    // Next state of the core.
    always_comb begin
        core_next = core_reg;
        wr_word = 32'h0000_0000;

        // Two-stage synchronisers for the pins; only the second stage is read.
        core_next.pin_meta = dio_in;
        core_next.pin_sync = core_reg.pin_meta;

        // Event input: two stages to synchronise, a third to find the edge.
        // At 20 MHz a 500 ns pulse spans ten clocks, so no edge is missed.
        core_next.ev_meta = event_count_input;
        core_next.ev_sync = core_reg.ev_meta;
        core_next.ev_prev = core_reg.ev_sync;
        rise = core_reg.ev_sync & ~core_reg.ev_prev;
        count_base = core_reg.count;

        // Write address and data are taken independently, in either order.
        if (s_axi_awvalid && core_reg.awready) begin
            core_next.aw_full = 1'b1;
            core_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && core_reg.wready) begin
            core_next.w_full = 1'b1;
            core_next.w_data = s_axi_wdata;
            core_next.w_strb = s_axi_wstrb;
        end
        if (core_reg.bvalid && s_axi_bready) begin
            core_next.bvalid = 1'b0;
        end

        // Once both halves are held the write is applied and answered.
        if (core_next.aw_full && core_next.w_full && !core_next.bvalid) begin
            core_next.aw_full = 1'b0;
            core_next.w_full = 1'b0;
            core_next.bvalid = 1'b1;
            core_next.bresp = `DIO_RESP_OKAY;
            wr_word = merge(reg_word(core_next.aw_addr, core_reg, link_bits),
                            core_next.w_data, core_next.w_strb);
            if (!is_mapped(core_next.aw_addr)) begin
                core_next.bresp = `DIO_RESP_SLVERR;
            end else begin
                case (core_next.aw_addr)
                    `DIO_OFS_CFG:   core_next.cfg = wr_word[`DIO_CFG_W-1:0];
                    `DIO_OFS_OUT_A: core_next.out_lat[7:0] = wr_word[7:0];
                    `DIO_OFS_OUT_B: core_next.out_lat[15:8] = wr_word[7:0];
                    `DIO_OFS_OUT_C: core_next.out_lat[23:16] = wr_word[7:0];
                    `DIO_OFS_COUNT: count_base = wr_word;
                    default:        core_next.bresp = `DIO_RESP_OKAY;
                endcase
            end
        end

        // A preset never swallows an edge seen in the same cycle; the sum wraps.
        core_next.count = count_base + `DIO_COUNT_W'(rise);

        // Read channel: one read at a time, answered on the next edge.
        if (core_reg.rvalid && s_axi_rready) begin
            core_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && core_reg.arready) begin
            core_next.rvalid = 1'b1;
            if (is_mapped(s_axi_araddr)) begin
                core_next.rdata = reg_word(s_axi_araddr, core_reg, link_bits);
                core_next.rresp = `DIO_RESP_OKAY;
            end else begin
                core_next.rdata = 32'h0000_0000;
                core_next.rresp = `DIO_RESP_SLVERR;
            end
        end

        // Ready flags are registered so every bus output comes from a flop.
        core_next.awready = !core_next.aw_full && !core_next.bvalid;
        core_next.wready = !core_next.w_full && !core_next.bvalid;
        core_next.arready = !core_next.rvalid;

        // Pin drive follows the latches; the enable is low where the port outputs.
        core_next.pin_drv = core_next.out_lat;
        core_next.pin_oe_n = ~dir_mask(core_next.cfg);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register. Reset leaves every port an input with its drive released.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_reg <= '0;
            core_reg.cfg <= `DIO_CFG_RESET;
            core_reg.pin_oe_n <= {`DIO_LINES{1'b1}};
        end else begin
            core_reg <= core_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flop.
    assign s_axi_awready = core_reg.awready;
    assign s_axi_wready  = core_reg.wready;
    assign s_axi_bvalid  = core_reg.bvalid;
    assign s_axi_bresp   = core_reg.bresp;
    assign s_axi_arready = core_reg.arready;
    assign s_axi_rvalid  = core_reg.rvalid;
    assign s_axi_rdata   = core_reg.rdata;
    assign s_axi_rresp   = core_reg.rresp;
    assign dio_out       = core_reg.pin_drv;
    assign dio_oe_n      = core_reg.pin_oe_n;
    assign status_lamp   = lamp_q;

endmodule : dio_event_counter_status

// >>> dio_field_model.sv
// Field model: switches on the digital lines and an event pulse source.
// Assumes the device drives a line only where its enable is low.
`timescale 1ns/10ps

module dio_field_model (
    input  wire logic        clk,
    input  wire logic [23:0] dio_out,
    input  wire logic [23:0] dio_oe_n,
    input  wire logic [23:0] field_val,
    output logic      [23:0] dio_in,
    output logic             ev
);
    // A pad shows the drive where enabled, else the switch, which never floats.
    assign dio_in = (~dio_oe_n & dio_out) | (dio_oe_n & field_val);

    initial ev = 1'h0;

    // Set the counter terminal level just after a rising edge.
    task automatic level(input logic b);
        @(posedge clk);
        ev <= b;
    endtask : level

    // Pulses with high and low each w cycles; w of 10 is the fastest legal rate.
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            level(1'h1);
            repeat (w - 1) @(posedge clk);
            level(1'h0);
            repeat (w - 1) @(posedge clk);
        end
    endtask : pulses
endmodule : dio_field_model

// >>> dio_params.svh
// Constants of the digital I/O, event counter and lamp block.
// Assumes one 20 MHz clock and an AXI4-Lite register bus.
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

// Geometry of the digital lines and the event counter.
`define DIO_PORT_W        8
`define DIO_LINES         24
`define DIO_COUNT_W       32
`define DIO_ADDR_W        8
`define DIO_CFG_W         5

// Register byte offsets.
`define DIO_OFS_CFG       8'h00
`define DIO_OFS_OUT_A     8'h04
`define DIO_OFS_OUT_B     8'h08
`define DIO_OFS_OUT_C     8'h0C
`define DIO_OFS_PIN_IN    8'h10
`define DIO_OFS_COUNT     8'h14
`define DIO_OFS_LINK      8'h18
`define DIO_OFS_LAST      8'h18

// Configuration register fields; a set direction bit makes the group an output.
`define DIO_CFG_DIR_A     0
`define DIO_CFG_DIR_B     1
`define DIO_CFG_DIR_CLO   2
`define DIO_CFG_DIR_CHI   3
`define DIO_CFG_SPLIT_C   4
`define DIO_CFG_RESET     5'h00

// Bus responses.
`define DIO_RESP_OKAY     2'h0
`define DIO_RESP_SLVERR   2'h2

// Lamp timing.
`define DIO_CLK_PERIOD_NS 50
`define DIO_BLINK_HALF_NS 100000000
`define DIO_BLINK_W       24
`define DIO_GREET_BLINKS  3
`define DIO_HALVES_W      3

`endif

// >>> dio_pkg.sv
// Types shared by the digital I/O block and its status lamp sequencer.
// Assumes dio_params.svh is on the include path.
`include "dio_params.svh"

package dio_pkg;

    // Status lamp sequencer states.
    typedef enum logic [1:0] {
        DIO_LAMP_OFF,
        DIO_LAMP_GREET,
        DIO_LAMP_STEADY,
        DIO_LAMP_BUSY
    } dio_lamp_e;

    // Whole state of the lamp sequencer.
    typedef struct packed {
        dio_lamp_e                 st;
        logic [`DIO_BLINK_W-1:0]   timer;
        logic [`DIO_HALVES_W-1:0]  halves;
        logic                      lamp;
    } dio_lamp_s;

    // Whole state of the digital I/O core and its bus slave.
    typedef struct packed {
        logic [`DIO_CFG_W-1:0]     cfg;
        logic [`DIO_LINES-1:0]     out_lat;
        logic [`DIO_LINES-1:0]     pin_meta;
        logic [`DIO_LINES-1:0]     pin_sync;
        logic [`DIO_LINES-1:0]     pin_drv;
        logic [`DIO_LINES-1:0]     pin_oe_n;
        logic                      ev_meta;
        logic                      ev_sync;
        logic                      ev_prev;
        logic [`DIO_COUNT_W-1:0]   count;
        logic                      aw_full;
        logic [`DIO_ADDR_W-1:0]    aw_addr;
        logic                      w_full;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } dio_core_s;

endpackage : dio_pkg

// >>> dio_status_lamp.sv
// Status lamp sequencer: off, greeting blinks, steady, or busy blinking.
// Assumes the link and transfer inputs come from the same clock.
`timescale 1ns/10ps
`include "dio_params.svh"

module dio_status_lamp #(
    parameter logic [`DIO_BLINK_W-1:0] BLINK_HALF_CYCLES = `DIO_BLINK_W'(`DIO_BLINK_HALF_NS / `DIO_CLK_PERIOD_NS)
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic link_up,
    input  wire logic xfer_busy,
    output logic      lamp_on
);

    dio_pkg::dio_lamp_s lamp_reg;
    dio_pkg::dio_lamp_s lamp_next;
    logic               half_done;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state. Loss of the link overrides every other state.
    always_comb begin
        lamp_next = lamp_reg;
        half_done = (lamp_reg.timer == BLINK_HALF_CYCLES - `DIO_BLINK_W'(1));
        lamp_next.timer = half_done ? '0 : lamp_reg.timer + `DIO_BLINK_W'(1);
        case (lamp_reg.st)
            dio_pkg::DIO_LAMP_OFF: begin
                lamp_next.lamp = 1'b0;
                lamp_next.timer = '0;
                if (link_up) begin
                    lamp_next.st = dio_pkg::DIO_LAMP_GREET;
                    lamp_next.halves = '0;
                    lamp_next.lamp = 1'b1;
                end
            end
            dio_pkg::DIO_LAMP_GREET: begin
                // Three on phases and three off phases, then steady.
                if (half_done) begin
                    lamp_next.lamp = ~lamp_reg.lamp;
                    lamp_next.halves = lamp_reg.halves + `DIO_HALVES_W'(1);
                    if (lamp_reg.halves == `DIO_HALVES_W'(2 * `DIO_GREET_BLINKS - 1)) begin
                        lamp_next.st = dio_pkg::DIO_LAMP_STEADY;
                        lamp_next.lamp = 1'b1;
                    end
                end
            end
            dio_pkg::DIO_LAMP_STEADY: begin
                lamp_next.lamp = 1'b1;
                lamp_next.timer = '0;
                if (xfer_busy) begin
                    lamp_next.st = dio_pkg::DIO_LAMP_BUSY;
                end
            end
            dio_pkg::DIO_LAMP_BUSY: begin
                if (half_done) begin
                    lamp_next.lamp = ~lamp_reg.lamp;
                end
                if (!xfer_busy) begin
                    lamp_next.st = dio_pkg::DIO_LAMP_STEADY;
                    lamp_next.lamp = 1'b1;
                    lamp_next.timer = '0;
                end
            end
            default: begin
                lamp_next.st = dio_pkg::DIO_LAMP_OFF;
            end
        endcase
        if (!link_up) begin
            lamp_next.st = dio_pkg::DIO_LAMP_OFF;
            lamp_next.lamp = 1'b0;
            lamp_next.timer = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lamp_reg <= '{st: dio_pkg::DIO_LAMP_OFF, timer: '0, halves: '0, lamp: 1'b0};
        end else begin
            lamp_reg <= lamp_next;
        end
    end

    assign lamp_on = lamp_reg.lamp;

endmodule : dio_status_lamp

// >>> test_dio_event_counter_status.sv
// Bench: a bus access table, then counter, lamp and reset cases.
// Assumes the field model and the checker are compiled with it.
`timescale 1ns/10ps
`include "dio_params.svh"

module test_dio_event_counter_status;
    typedef struct packed {logic rd; logic [7:0] a; logic [31:0] d; logic [1:0] resp; logic [23:0] oe;} dio_row_s;
    logic        clk = 1'h0, sys_rst = 1'h1, link = 1'h0, busy = 1'h0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, dat;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, lamp, ev;
    logic [1:0]  bresp, rresp, rsp;
    logic [23:0] din, dout, oe_n;
    int          miscompares = 0, check_count = 0, cyc = 0, f, t;
    dio_row_s    rows [] = '{
        '{1'h0, 8'h04, 32'h5A, 2'h0, 24'hFFFFFF}, '{1'h0, 8'h08, 32'hC3, 2'h0, 24'hFFFFFF},
        '{1'h0, 8'h0C, 32'h96, 2'h0, 24'hFFFFFF}, '{1'h1, 8'h10, 32'hF00F33, 2'h0, 24'hFFFFFF},
        '{1'h0, 8'h00, 32'h01, 2'h0, 24'hFFFF00}, '{1'h1, 8'h10, 32'hF00F5A, 2'h0, 24'hFFFF00},
        '{1'h0, 8'h00, 32'h02, 2'h0, 24'hFF00FF}, '{1'h1, 8'h10, 32'hF0C333, 2'h0, 24'hFF00FF},
        '{1'h0, 8'h00, 32'h04, 2'h0, 24'h00FFFF}, '{1'h1, 8'h10, 32'h960F33, 2'h0, 24'h00FFFF},
        '{1'h0, 8'h00, 32'h14, 2'h0, 24'hF0FFFF}, '{1'h1, 8'h10, 32'hF60F33, 2'h0, 24'hF0FFFF},
        '{1'h0, 8'h00, 32'h18, 2'h0, 24'h0FFFFF}, '{1'h1, 8'h10, 32'h900F33, 2'h0, 24'h0FFFFF},
        '{1'h1, 8'h00, 32'h18, 2'h0, 24'h0FFFFF}, '{1'h0, 8'h1C, 32'h00, 2'h2, 24'h0FFFFF},
        '{1'h1, 8'h1C, 32'h00, 2'h2, 24'h0FFFFF}, '{1'h0, 8'h02, 32'h07, 2'h2, 24'h0FFFFF},
        '{1'h0, 8'h10, 32'h07, 2'h0, 24'h0FFFFF}, '{1'h1, 8'h04, 32'h5A, 2'h0, 24'h0FFFFF}};

    dio_event_counter_status #(.BLINK_HALF_CYCLES(24'h8)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .usb_link_up(link),
        .usb_xfer_busy(busy), .dio_in(din), .dio_out(dout), .dio_oe_n(oe_n),
        .event_count_input(ev), .status_lamp(lamp));
    dio_field_model fld_u (.clk(clk), .dio_out(dout), .dio_oe_n(oe_n), .field_val(24'hF00F33),
        .dio_in(din), .ev(ev));

    ////////////////////////////////////////////////////////////////////////
    // Verdict, check and bus tasks; handshakes are sampled at the falling edge.
    task automatic test_done();
        $display("TB: %0d checks, %0d miscompares", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end while ((awvalid && !ta) || (wvalid && !tw));
        do @(negedge clk); while (!bvalid);
        r = bresp;
        @(posedge clk);
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'h0;
        do @(negedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'h0;
    endtask : rd

    // Counts lamp falls and changes over n cycles.
    task automatic watch(input int n, output int falls, output int tog);
        logic prev;
        falls = 0;
        tog = 0;
        prev = lamp;
        repeat (n) begin
            @(negedge clk);
            if (prev && !lamp) falls++;
            if (prev !== lamp) tog++;
            prev = lamp;
        end
    endtask : watch

    ////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling against hangs.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            test_done();
        end
    end

    // Table, counter and lamp cases, then a mid-run reset.
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        foreach (rows[i]) begin
            if (rows[i].rd) begin
                rd(rows[i].a, dat, rsp);
                check(dat, rows[i].d);
            end else wr(rows[i].a, rows[i].d, rsp);
            check(rsp, rows[i].resp);
            check(oe_n, rows[i].oe);
        end
        $display("TB: table done");
        wr(`DIO_OFS_COUNT, 32'hFFFFFFFE, rsp);
        fld_u.pulses(3, 10);
        repeat (5) @(posedge clk);
        rd(`DIO_OFS_COUNT, dat, rsp);
        check(dat, 32'h1);
        for (int k = 1; k >= 0; k--) begin
            fld_u.level(k[0]);
            repeat (5) @(posedge clk);
            rd(`DIO_OFS_COUNT, dat, rsp);
            check(dat, 32'h2);
        end
        $display("TB: counter done");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            link <= 1'h1;
            watch(70, f, t);
            check(f, 3);
            check(lamp, 1'h1);
            if (k == 0) begin
                @(posedge clk);
                busy <= 1'h1;
                watch(40, f, t);
                check(t >= 4, 1'h1);
                @(posedge clk);
                busy <= 1'h0;
                watch(3, f, t);
                check(lamp, 1'h1);
                rd(`DIO_OFS_LINK, dat, rsp);
                check(dat, 32'h5);
            end
            @(posedge clk);
            link <= 1'h0;
            watch(3, f, t);
            check(lamp, 1'h0);
        end
        $display("TB: lamp done");
        wr(`DIO_OFS_CFG, 32'h0F, rsp);
        check(oe_n, 24'h000000);
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        check(oe_n, 24'hFFFFFF);
        sys_rst <= 1'h0;
        rd(`DIO_OFS_COUNT, dat, rsp);
        check(dat, 32'h0);
        rd(`DIO_OFS_CFG, dat, rsp);
        check(dat, 32'h0);
        $display("TB: reset done");
        test_done();
    end
endmodule : test_dio_event_counter_status
